// file: gige_mac_control_status_regs_test.sv
// Purpose: Self-checking bench for the MAC control and status registers
// Assumes: Byte register port, inputs driven at the falling edge
// Notes:   Event and gap tables run in loops; the other cases are written out by hand
`timescale 1ns/1ps
module gige_mac_control_status_regs_test;
  logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, link_up = 0;
  logic        rx_fifo_full = 0, rx_fifo_empty = 0, dma_ready = 0;
  logic [7:0]  reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, rb;
  logic [15:0] ev = 16'h0000, st;
  logic [63:0] dma_addr;
  logic [31:0] dma_data;
  // Dump words as seen, and the image that the event counts should give
  logic [31:0] img [16] = '{default: 32'hFFFF_FFFF};
  logic [31:0] want [16] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1_0000, 32'h2, 32'h1,
                             32'h1, 32'h0, 32'h1, 32'h0, 32'h1, 32'h1_0002};
  logic [5:0]  ifg_extra_bits;
  logic [2:0]  tx_burst_limit;
  logic [1:0]  loopback_select;
  logic        irq, dma_valid, rx_path_on, tx_path_on, soft_reset_busy, fifo_reinit, ring_reload;
  logic        high_queue_poll, normal_queue_poll, ifg_code_ok, digital_loopback, suppress_fcs;
  int          n_errors = 0, cmp_count = 0, nw = 0;
  // Event index beside the status word it should leave
  logic [19:0] rows [7] = '{20'h60008, 20'h80004, 20'h90001, 20'hA0002, 20'hB0040, 20'hC0080, 20'hD0010};
  // Gap code beside the extra bit times
  logic [8:0]  gaps [5] = '{9'h0C0, 9'h148, 9'h1D0, 9'h058, 9'h0B0};

  gmr_regs i_gmr_regs (.*, .ev_align_error(ev[0]), .ev_tx_single_col(ev[1]), .ev_tx_multi_col(ev[2]),
    .ev_rx_unicast(ev[3]), .ev_rx_broadcast(ev[4]), .ev_rx_multicast(ev[5]), .ev_tx_abort(ev[6]),
    .ev_tx_underrun(ev[7]), .ev_tx_done(ev[8]), .ev_rx_done(ev[9]), .ev_rx_bad_frame(ev[10]),
    .ev_rx_overflow(ev[11]), .ev_tx_desc_missing(ev[12]), .ev_rx_desc_missing(ev[13]),
    .high_queue_drained(ev[14]), .normal_queue_drained(ev[15]));

  always #50 mclk = ~mclk;

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge mclk);
    reg_wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a);
    @(negedge mclk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge mclk);
    reg_rd = 1'b0;
    rb = reg_rdata;
  endtask

  task automatic rd16;
    rd(8'h3E);
    st[7:0] = rb;
    rd(8'h3F);
    st[15:8] = rb;
  endtask

  task automatic pulse(input int i);
    @(negedge mclk);
    ev[i] = 1'b1;
    @(negedge mclk);
    ev[i] = 1'b0;
  endtask

  task automatic complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Whole run is well under a thousand cycles
  initial
  begin
    #2000000;
    n_errors++;
    complete_run();
  end

  initial
  begin
    repeat (12) @(negedge mclk);
    rst_n = 1'b1;
    chk("reset", 6'h38, {tx_burst_limit, ifg_code_ok, irq, dma_valid});
    for (int i = 0; i < 7; i++)
    begin
      pulse(rows[i][19:16]);
      rd16();
      chk("stat", rows[i][15:0], st);
      wr(8'h3E, 8'hFF);
      rd16();
      chk("clr", 16'h0000, st);
    end
    link_up = 1'b1;
    wr(8'h3E, 8'h00);
    rd16();
    chk("link", 16'h0020, st);
    wr(8'h3C, 8'h20);
    repeat (2) @(negedge mclk);
    chk("irq", 1'b1, irq);
    wr(8'h3E, 8'h20);
    repeat (2) @(negedge mclk);
    chk("irq", 1'b0, irq);
    $display("Status test done");
    wr(8'h3C, 8'h40);
    pulse(11);
    rx_fifo_full = 1'b1;
    @(negedge mclk);
    rx_fifo_full = 1'b0;
    rx_fifo_empty = 1'b1;
    rd16();
    chk("ovfl", 16'h0240, st);
    wr(8'h3C, 8'h00);
    rd16();
    chk("ovfl", 16'h0200, st);
    wr(8'h3F, 8'h02);
    wr(8'h38, 8'hC1);
    rd16();
    chk("swirq", 16'h0100, st);
    chk("poll", 2'b11, {high_queue_poll, normal_queue_poll});
    pulse(14);
    rd(8'h38);
    chk("poll", 8'h41, rb);
    wr(8'h3F, 8'h01);
    pulse(15);
    rd(8'h38);
    chk("poll", 8'h00, rb);
    $display("Poll test done");
    // Receive and transmit go on before the configuration is touched
    wr(8'h37, 8'h0C);
    chk("paths", 2'b11, {rx_path_on, tx_path_on});
    for (int i = 0; i < 5; i++)
    begin
      wr(8'h43, {6'h00, gaps[i][7:6]});
      wr(8'h42, {4'h0, gaps[i][8], 3'h0});
      @(negedge mclk);
      chk("ifg", {4'h1, gaps[i][5:0]}, {loopback_select, digital_loopback, ifg_code_ok, ifg_extra_bits});
    end
    wr(8'h43, 8'hFF);
    rd(8'h43);
    chk("ver", 8'h03, rb);
    wr(8'h42, 8'hFF);
    rd(8'h42);
    chk("cfg", 8'h0F, rb);
    chk("lbk", 4'hF, {loopback_select, digital_loopback, suppress_fcs});
    wr(8'h41, 8'h00);
    @(negedge mclk);
    chk("burst", 3'h0, tx_burst_limit);
    wr(8'h39, 8'hFF);
    rd(8'h39);
    chk("unmap", 8'h00, rb);
    $display("Config test done");
    wr(8'h37, 8'h1C);
    chk("srst", 5'h13, {soft_reset_busy, rx_path_on, tx_path_on, fifo_reinit, ring_reload});
    repeat (3) @(negedge mclk);
    rd(8'h37);
    chk("srst", 8'h00, rb);
    $display("Soft reset test done");
    // Compare of 5, then a restart: the match comes six edges after the restart
    wr(8'h58, 8'h05);
    wr(8'h48, 8'h00);
    repeat (8) @(negedge mclk);
    rd16();
    chk("timeout", 16'h4000, st);
    wr(8'h3F, 8'h40);
    $display("Timer test done");
    for (int i = 0; i < 8; i++)
      pulse(i);
    pulse(1);
    dma_ready = 1'b1;
    wr(8'h10, 8'h48);
    for (int c = 0; c < 30; c++)
    begin
      if (dma_valid === 1'b1 && dma_addr[63:6] === 58'h1)
      begin
        nw++;
        img[dma_addr[5:2]] = dma_data;
      end
      @(negedge mclk);
    end
    chk("words", 16, nw);
    for (int i = 0; i < 16; i++)
      chk("image", want[i], img[i]);
    rd(8'h10);
    chk("dump", 8'h40, rb);
    $display("Dump test done");
    complete_run();
  end
endmodule

// file: gmr_pkg.sv
// Purpose: Shared constants and state types for the MAC control and status register block
// Assumes: Byte-wide register port, one clock domain
// Notes:   Offsets are byte addresses on the register port
package gmr_pkg;

  // Register byte offsets
  localparam logic [7:0] GMR_OFF_DUMP      = 8'h10;
  localparam logic [7:0] GMR_OFF_DUMP_LAST = 8'h17;
  localparam logic [7:0] GMR_OFF_CMD       = 8'h37;
  localparam logic [7:0] GMR_OFF_POLL      = 8'h38;
  localparam logic [7:0] GMR_OFF_MASK      = 8'h3C;
  localparam logic [7:0] GMR_OFF_STAT      = 8'h3E;
  localparam logic [7:0] GMR_OFF_TXCFG     = 8'h40;
  localparam logic [7:0] GMR_OFF_TIMER     = 8'h48;
  localparam logic [7:0] GMR_OFF_TCMP      = 8'h58;

  // Field positions
  localparam int GMR_DUMP_GO_BIT = 3;
  localparam int GMR_CMD_SRST    = 4;
  localparam int GMR_CMD_RX_ON   = 3;
  localparam int GMR_CMD_TX_ON   = 2;
  localparam int GMR_POLL_HIGH   = 7;
  localparam int GMR_POLL_NORMAL = 6;
  localparam int GMR_POLL_FSW    = 0;
  localparam int GMR_ST_TIMEOUT  = 14;
  localparam int GMR_ST_DRAINED  = 9;
  localparam int GMR_ST_SWIRQ    = 8;
  localparam int GMR_ST_TXDESC   = 7;
  localparam int GMR_ST_OVFL     = 6;
  localparam int GMR_ST_LINK     = 5;
  localparam int GMR_ST_RXDESC   = 4;
  localparam int GMR_ST_TXABORT  = 3;
  localparam int GMR_ST_TXDONE   = 2;
  localparam int GMR_ST_RXBAD    = 1;
  localparam int GMR_ST_RXDONE   = 0;

  // Implemented status and mask bits
  localparam logic [15:0] GMR_STAT_IMPL = 16'h43FF;

  // Reset values and counts
  localparam logic [3:0] GMR_SRST_LAST  = 4'h3;
  localparam logic [3:0] GMR_DUMP_LAST  = 4'hF;
  localparam logic [2:0] GMR_BURST_RST  = 3'h7;

  // Gap codes and extra bit times
  localparam logic [2:0] GMR_GAP_BASE = 3'h3;
  localparam logic [2:0] GMR_GAP_P8   = 3'h5;
  localparam logic [2:0] GMR_GAP_P16  = 3'h7;
  localparam logic [2:0] GMR_GAP_P24  = 3'h1;
  localparam logic [2:0] GMR_GAP_P48  = 3'h2;
  localparam logic [1:0] GMR_LBK_NORMAL  = 2'h0;
  localparam logic [1:0] GMR_LBK_DIGITAL = 2'h3;

  typedef enum logic [0:0] {
    GMR_DUMP_IDLE = 1'b0,
    GMR_DUMP_SEND = 1'b1
  } gmr_dump_e;

  typedef struct packed {
    gmr_dump_e   dump_st;
    logic [57:0] dump_base;
    logic [3:0]  dump_idx;
    logic        dma_valid;
    logic [63:0] dma_addr;
    logic [31:0] dma_data;
    logic        rx_on;
    logic        tx_on;
    logic        srst;
    logic [3:0]  srst_cnt;
    logic        fifo_reinit;
    logic        ring_reload;
    logic        poll_high;
    logic        poll_normal;
    logic        fsw;
    logic [15:0] mask;
    logic [15:0] stat;
    logic        gap_high;
    logic [1:0]  gap_low;
    logic [1:0]  lbk;
    logic        nofcs;
    logic [2:0]  burst;
    logic [5:0]  ifg_extra;
    logic        ifg_ok;
    logic        dlb;
    logic [31:0] timer;
    logic [31:0] tcmp;
    logic        link_q;
    logic        full_seen;
    logic [15:0] c_align;
    logic [31:0] c_col1;
    logic [31:0] c_colm;
    logic [63:0] c_uni;
    logic [63:0] c_bcast;
    logic [31:0] c_mcast;
    logic [15:0] c_abort;
    logic [15:0] c_under;
    logic [7:0]  rdata;
    logic        irq;
  } gmr_state_s;

endpackage

// file: gmr_regs.sv
// Purpose: Control and status registers of a gigabit Ethernet MAC, with counter dump engine
// Assumes: Byte-wide synchronous register port, read data one cycle after reg_rd
// Notes:   Dump image is sixteen 32-bit little-endian words written to host memory
//
// Functional notes
// - Dump image: align errors at byte 30, single and multi collision counts at 32, 36.
// - Dump image: unicast 40, broadcast 48, multicast 56, abort 60, underrun 62.
// - Dump request bit 3 starts the memory dump and clears itself when finished.
// - Soft reset disables both paths, reinits FIFOs, reloads ring pointers, keeps addresses.
// - Soft reset bit reads one while reset runs and self-clears afterwards.
// - Poll bits 7 and 6 are set by writing one, cleared when that queue drains.
// - Writing one to poll bit 0 sets status bit 8; clears after status bit 8 clears.
// - Mask bits enable status bits 14, 9..0 onto the interrupt.
// - Overflow status clears by software when masked on, by hardware on drain otherwise.
// - Status bit 14 sets when the timer equals the compare value.
// - Status bit 9 sets when the receive FIFO empties after being full.
// - Status bit 7 on missing transmit descriptor, bit 4 on missing receive descriptor.
// - Status bit 6 sets on receive FIFO overflow.
// - Status bit 5 sets on every link status change.
// - Status bit 3 on transmit abort, bit 2 on successful transmit.
// - Status bit 1 on bad received frame, bit 0 on good received frame.
// - Writing one to a status bit clears it; zero leaves it.
// - Three-bit gap code selects base gap plus 0, 8, 16, 24 or 48 bit times.
// - Burst field 10-8 limits transmit bursts, 16 bytes doubling, 111 unlimited.
// - Version bits 29, 28, 26, 23 are read-only.
// - Timeout status never sets while the compare value is zero.
`timescale 1ns/1ps
module gmr_regs
#(
  parameter logic [3:0] SILICON_VERSION = 4'h0  // Arbitrary value
)
(
  input  wire logic        mclk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  output logic             irq,
  input  wire logic        ev_align_error,
  input  wire logic        ev_tx_single_col,
  input  wire logic        ev_tx_multi_col,
  input  wire logic        ev_rx_unicast,
  input  wire logic        ev_rx_broadcast,
  input  wire logic        ev_rx_multicast,
  input  wire logic        ev_tx_abort,
  input  wire logic        ev_tx_underrun,
  input  wire logic        ev_tx_done,
  input  wire logic        ev_rx_done,
  input  wire logic        ev_rx_bad_frame,
  input  wire logic        ev_rx_overflow,
  input  wire logic        ev_tx_desc_missing,
  input  wire logic        ev_rx_desc_missing,
  input  wire logic        high_queue_drained,
  input  wire logic        normal_queue_drained,
  input  wire logic        link_up,
  input  wire logic        rx_fifo_full,
  input  wire logic        rx_fifo_empty,
  output logic             dma_valid,
  output logic      [63:0] dma_addr,
  output logic      [31:0] dma_data,
  input  wire logic        dma_ready,
  output logic             rx_path_on,
  output logic             tx_path_on,
  output logic             soft_reset_busy,
  output logic             fifo_reinit,
  output logic             ring_reload,
  output logic             high_queue_poll,
  output logic             normal_queue_poll,
  output logic      [5:0]  ifg_extra_bits,
  output logic             ifg_code_ok,
  output logic      [1:0]  loopback_select,
  output logic             digital_loopback,
  output logic             suppress_fcs,
  output logic      [2:0]  tx_burst_limit
);

  gmr_pkg::gmr_state_s s_q;
  gmr_pkg::gmr_state_s s_d;
  logic [15:0]         masked_stat;

  function automatic logic hit(input logic [7:0] a, input logic [7:0] lo, input logic [7:0] hi);
    hit = (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [7:0] lane(input logic [31:0] w, input logic [1:0] l);
    lane = w[8*l +: 8];
  endfunction

  function automatic logic [31:0] txcfg_word(input gmr_pkg::gmr_state_s s);
    txcfg_word = {2'b00, SILICON_VERSION[3], SILICON_VERSION[2], 1'b0, SILICON_VERSION[1],
                  s.gap_low, SILICON_VERSION[0], 3'b000, s.gap_high, s.lbk, s.nofcs,
                  5'b00000, s.burst, 8'h00};
  endfunction

  // Image words in memory order; bytes 0..29 belong to counters kept elsewhere
  function automatic logic [31:0] dump_word(input gmr_pkg::gmr_state_s s, input logic [3:0] i);
    case (i)
      4'h7:    dump_word = {s.c_align, 16'h0000};
      4'h8:    dump_word = s.c_col1;
      4'h9:    dump_word = s.c_colm;
      4'hA:    dump_word = s.c_uni[31:0];
      4'hB:    dump_word = s.c_uni[63:32];
      4'hC:    dump_word = s.c_bcast[31:0];
      4'hD:    dump_word = s.c_bcast[63:32];
      4'hE:    dump_word = s.c_mcast;
      4'hF:    dump_word = {s.c_under, s.c_abort};
      default: dump_word = 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [7:0] rd_byte(input gmr_pkg::gmr_state_s s, input logic [7:0] a);
    logic [63:0] dump_reg;
    dump_reg = {s.dump_base, 2'b00, (s.dump_st == gmr_pkg::GMR_DUMP_SEND), 3'b000};
    rd_byte = 8'h00;
    if (hit(a, gmr_pkg::GMR_OFF_DUMP, gmr_pkg::GMR_OFF_DUMP_LAST))
      rd_byte = dump_reg[8*a[2:0] +: 8];
    else if (a == gmr_pkg::GMR_OFF_CMD)
      rd_byte = {3'b000, s.srst, s.rx_on, s.tx_on, 2'b00};
    else if (a == gmr_pkg::GMR_OFF_POLL)
      rd_byte = {s.poll_high, s.poll_normal, 5'b00000, s.fsw};
    else if (hit(a, gmr_pkg::GMR_OFF_MASK, gmr_pkg::GMR_OFF_MASK + 8'h01))
      rd_byte = lane({16'h0000, s.mask}, a[1:0] & 2'b01);
    else if (hit(a, gmr_pkg::GMR_OFF_STAT, gmr_pkg::GMR_OFF_STAT + 8'h01))
      rd_byte = lane({16'h0000, s.stat}, a[1:0] & 2'b01);
    else if (hit(a, gmr_pkg::GMR_OFF_TXCFG, gmr_pkg::GMR_OFF_TXCFG + 8'h03))
      rd_byte = lane(txcfg_word(s), a[1:0]);
    else if (hit(a, gmr_pkg::GMR_OFF_TIMER, gmr_pkg::GMR_OFF_TIMER + 8'h03))
      rd_byte = lane(s.timer, a[1:0]);
    else if (hit(a, gmr_pkg::GMR_OFF_TCMP, gmr_pkg::GMR_OFF_TCMP + 8'h03))
      rd_byte = lane(s.tcmp, a[1:0]);
  endfunction

  function automatic logic [6:0] gap_decode(input logic [2:0] code);
    case (code)
      gmr_pkg::GMR_GAP_BASE: gap_decode = {1'b1, 6'd0};
      gmr_pkg::GMR_GAP_P8:   gap_decode = {1'b1, 6'd8};
      gmr_pkg::GMR_GAP_P16:  gap_decode = {1'b1, 6'd16};
      gmr_pkg::GMR_GAP_P24:  gap_decode = {1'b1, 6'd24};
      gmr_pkg::GMR_GAP_P48:  gap_decode = {1'b1, 6'd48};
      default:               gap_decode = {1'b0, 6'd0};
    endcase
  endfunction

  always_comb
  begin
    logic [15:0] set_v;
    logic [15:0] clr_v;
    logic        wr_cmd;
    logic        wr_poll;
    logic [6:0]  gap;
    logic [3:0]  nxt_idx;
    set_v   = 16'h0000;
    clr_v   = 16'h0000;
    wr_cmd  = reg_wr && (reg_addr == gmr_pkg::GMR_OFF_CMD);
    wr_poll = reg_wr && (reg_addr == gmr_pkg::GMR_OFF_POLL);
    gap     = 7'h00;
    nxt_idx = s_q.dump_idx + 4'h1;
    s_d = s_q;
    s_d.fifo_reinit = 1'b0;
    s_d.ring_reload = 1'b0;

    // Counter dump engine
    case (s_q.dump_st)
      gmr_pkg::GMR_DUMP_IDLE:
      begin
        if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_DUMP && reg_wdata[gmr_pkg::GMR_DUMP_GO_BIT])
        begin
          s_d.dump_st   = gmr_pkg::GMR_DUMP_SEND;
          s_d.dump_idx  = 4'h0;
          s_d.dma_valid = 1'b1;
          s_d.dma_addr  = {s_q.dump_base[57:2], reg_wdata[7:6], 6'h00};
          s_d.dma_data  = dump_word(s_q, 4'h0);
        end
      end
      gmr_pkg::GMR_DUMP_SEND:
      begin
        if (dma_ready)
        begin
          if (s_q.dump_idx == gmr_pkg::GMR_DUMP_LAST)
          begin
            s_d.dump_st   = gmr_pkg::GMR_DUMP_IDLE;
            s_d.dma_valid = 1'b0;
          end
          else
          begin
            s_d.dump_idx = nxt_idx;
            s_d.dma_addr = {s_q.dma_addr[63:6], nxt_idx, 2'b00};
            s_d.dma_data = dump_word(s_q, nxt_idx);
          end
        end
      end
      default:
      begin
        s_d.dump_st   = gmr_pkg::GMR_DUMP_IDLE;
        s_d.dma_valid = 1'b0;
      end
    endcase
    // Base is frozen while a dump runs so the address stays coherent
    if (reg_wr && s_q.dump_st == gmr_pkg::GMR_DUMP_IDLE &&
        hit(reg_addr, gmr_pkg::GMR_OFF_DUMP, gmr_pkg::GMR_OFF_DUMP_LAST))
    begin
      if (reg_addr[2:0] == 3'h0)
        s_d.dump_base[1:0] = reg_wdata[7:6];
      else
        s_d.dump_base[8*reg_addr[2:0]-6 +: 8] = reg_wdata;
    end

    // Command register and soft reset
    if (s_q.srst)
    begin
      s_d.rx_on = 1'b0;
      s_d.tx_on = 1'b0;
      if (s_q.srst_cnt == 4'h0)
        s_d.srst = 1'b0;
      else
        s_d.srst_cnt = s_q.srst_cnt - 4'h1;
    end
    else if (wr_cmd)
    begin
      if (reg_wdata[gmr_pkg::GMR_CMD_SRST])
      begin
        s_d.srst        = 1'b1;
        s_d.srst_cnt    = gmr_pkg::GMR_SRST_LAST;
        s_d.rx_on       = 1'b0;
        s_d.tx_on       = 1'b0;
        s_d.fifo_reinit = 1'b1;
        s_d.ring_reload = 1'b1;
      end
      else
      begin
        s_d.rx_on = reg_wdata[gmr_pkg::GMR_CMD_RX_ON];
        s_d.tx_on = reg_wdata[gmr_pkg::GMR_CMD_TX_ON];
      end
    end

    // Queue polling; a write of one wins over a drain in the same cycle
    s_d.poll_high   = (s_q.poll_high & ~high_queue_drained) |
                      (wr_poll & reg_wdata[gmr_pkg::GMR_POLL_HIGH]);
    s_d.poll_normal = (s_q.poll_normal & ~normal_queue_drained) |
                      (wr_poll & reg_wdata[gmr_pkg::GMR_POLL_NORMAL]);
    s_d.fsw         = (s_q.fsw & s_q.stat[gmr_pkg::GMR_ST_SWIRQ]) |
                      (wr_poll & reg_wdata[gmr_pkg::GMR_POLL_FSW]);

    // Mask register
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_MASK)
      s_d.mask[7:0] = reg_wdata & gmr_pkg::GMR_STAT_IMPL[7:0];
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_MASK + 8'h01)
      s_d.mask[15:8] = reg_wdata & gmr_pkg::GMR_STAT_IMPL[15:8];

    // Timer; any byte write restarts the count
    if (reg_wr && hit(reg_addr, gmr_pkg::GMR_OFF_TIMER, gmr_pkg::GMR_OFF_TIMER + 8'h03))
      s_d.timer = 32'h0000_0000;
    else
      s_d.timer = s_q.timer + 32'h0000_0001;
    if (reg_wr && hit(reg_addr, gmr_pkg::GMR_OFF_TCMP, gmr_pkg::GMR_OFF_TCMP + 8'h03))
      s_d.tcmp[8*reg_addr[1:0] +: 8] = reg_wdata;

    // Status sources
    set_v[gmr_pkg::GMR_ST_TIMEOUT] = (s_q.tcmp != 32'h0000_0000) && (s_q.timer == s_q.tcmp);
    s_d.link_q    = link_up;
    s_d.full_seen = (s_q.full_seen | rx_fifo_full) & ~(s_q.full_seen & rx_fifo_empty);
    set_v[gmr_pkg::GMR_ST_DRAINED] = s_q.full_seen & rx_fifo_empty;
    set_v[gmr_pkg::GMR_ST_SWIRQ]   = wr_poll & reg_wdata[gmr_pkg::GMR_POLL_FSW];
    set_v[gmr_pkg::GMR_ST_TXDESC]  = ev_tx_desc_missing;
    set_v[gmr_pkg::GMR_ST_OVFL]    = ev_rx_overflow;
    set_v[gmr_pkg::GMR_ST_LINK]    = link_up ^ s_q.link_q;
    set_v[gmr_pkg::GMR_ST_RXDESC]  = ev_rx_desc_missing;
    set_v[gmr_pkg::GMR_ST_TXABORT] = ev_tx_abort;
    set_v[gmr_pkg::GMR_ST_TXDONE]  = ev_tx_done;
    set_v[gmr_pkg::GMR_ST_RXBAD]   = ev_rx_bad_frame;
    set_v[gmr_pkg::GMR_ST_RXDONE]  = ev_rx_done;

    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_STAT)
      clr_v[7:0] = reg_wdata;
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_STAT + 8'h01)
      clr_v[15:8] = reg_wdata;
    // With overflow masked off nobody services it, so the drain clears it
    if (!s_q.mask[gmr_pkg::GMR_ST_OVFL] && rx_fifo_empty)
      clr_v[gmr_pkg::GMR_ST_OVFL] = 1'b1;
    // Set wins over clear
    s_d.stat = ((s_q.stat & ~clr_v) | set_v) & gmr_pkg::GMR_STAT_IMPL;
    s_d.irq  = |(s_d.stat & s_d.mask);

    // Transmit configuration
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_TXCFG + 8'h01)
      s_d.burst = reg_wdata[2:0];
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_TXCFG + 8'h02)
    begin
      s_d.nofcs    = reg_wdata[0];
      s_d.lbk      = reg_wdata[2:1];
      s_d.gap_high = reg_wdata[3];
    end
    if (reg_wr && reg_addr == gmr_pkg::GMR_OFF_TXCFG + 8'h03)
      s_d.gap_low = reg_wdata[1:0];
    gap           = gap_decode({s_d.gap_high, s_d.gap_low});
    s_d.ifg_ok    = gap[6];
    s_d.ifg_extra = gap[5:0];
    s_d.dlb       = (s_d.lbk == gmr_pkg::GMR_LBK_DIGITAL);

    // Statistics counters
    if (ev_align_error)   s_d.c_align = s_q.c_align + 16'h0001;
    if (ev_tx_single_col) s_d.c_col1  = s_q.c_col1 + 32'h0000_0001;
    if (ev_tx_multi_col)  s_d.c_colm  = s_q.c_colm + 32'h0000_0001;
    if (ev_rx_unicast)    s_d.c_uni   = s_q.c_uni + 64'h1;
    if (ev_rx_broadcast)  s_d.c_bcast = s_q.c_bcast + 64'h1;
    if (ev_rx_multicast)  s_d.c_mcast = s_q.c_mcast + 32'h0000_0001;
    if (ev_tx_abort)      s_d.c_abort = s_q.c_abort + 16'h0001;
    if (ev_tx_underrun)   s_d.c_under = s_q.c_under + 16'h0001;

    if (reg_rd)
      s_d.rdata = rd_byte(s_q, reg_addr);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_q       <= '0;
      s_q.burst <= gmr_pkg::GMR_BURST_RST;
    end
    else
      s_q <= s_d;
  end

  assign masked_stat       = s_q.stat & s_q.mask;
  assign reg_rdata         = s_q.rdata;
  assign irq               = s_q.irq;
  assign dma_valid         = s_q.dma_valid;
  assign dma_addr          = s_q.dma_addr;
  assign dma_data          = s_q.dma_data;
  assign rx_path_on        = s_q.rx_on;
  assign tx_path_on        = s_q.tx_on;
  assign soft_reset_busy   = s_q.srst;
  assign fifo_reinit       = s_q.fifo_reinit;
  assign ring_reload       = s_q.ring_reload;
  assign high_queue_poll   = s_q.poll_high;
  assign normal_queue_poll = s_q.poll_normal;
  assign ifg_extra_bits    = s_q.ifg_extra;
  assign ifg_code_ok       = s_q.ifg_ok;
  assign loopback_select   = s_q.lbk;
  assign digital_loopback  = s_q.dlb;
  assign suppress_fcs      = s_q.nofcs;
  assign tx_burst_limit    = s_q.burst;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  dump_self_clear_a: assert property (
    (s_q.dump_st == gmr_pkg::GMR_DUMP_SEND && dma_ready && s_q.dump_idx == gmr_pkg::GMR_DUMP_LAST)
    |=> (s_q.dump_st == gmr_pkg::GMR_DUMP_IDLE && !dma_valid))
    else $error("dump request bit did not clear after last word");
  srst_hold_a: assert property (
    (reg_wr && reg_addr == gmr_pkg::GMR_OFF_CMD && reg_wdata[4] && !s_q.srst)
    |=> soft_reset_busy[*4] ##1 !soft_reset_busy)
    else $error("soft reset busy length wrong");
  paths_off_a: assert property (
    soft_reset_busy |-> (!rx_path_on && !tx_path_on))
    else $error("path enabled during soft reset");
  rx_enable_a: assert property (
    (reg_wr && reg_addr == gmr_pkg::GMR_OFF_CMD && !s_q.srst && !reg_wdata[4])
    |=> (rx_path_on == $past(reg_wdata[3]) && tx_path_on == $past(reg_wdata[2])))
    else $error("path enables do not follow command write");
  sw_irq_set_a: assert property (
    (reg_wr && reg_addr == gmr_pkg::GMR_OFF_POLL && reg_wdata[0])
    |=> (s_q.stat[8] && s_q.fsw))
    else $error("forced interrupt did not set status");
  stat_clear_a: assert property (
    (reg_wr && reg_addr == gmr_pkg::GMR_OFF_STAT && reg_wdata[2] && !ev_tx_done)
    |=> !s_q.stat[2])
    else $error("write one did not clear status bit");
  irq_mask_a: assert property (
    irq == |masked_stat)
    else $error("interrupt output disagrees with mask and status");
  timeout_zero_a: assert property (
    (s_q.tcmp == 32'h0000_0000) |=> !$rose(s_q.stat[14]))
    else $error("timeout set with zero compare value");
  ovfl_auto_a: assert property (
    (s_q.stat[6] && !s_q.mask[6] && rx_fifo_empty && !ev_rx_overflow) |=> !s_q.stat[6])
    else $error("overflow status not cleared on drain");
  drained_a: assert property (
    (s_q.full_seen && rx_fifo_empty) |=> s_q.stat[9])
    else $error("drained status not set");

  dump_done_c: cover property (
    s_q.dump_st == gmr_pkg::GMR_DUMP_SEND ##1 s_q.dump_st == gmr_pkg::GMR_DUMP_IDLE);
  srst_done_c: cover property ($fell(soft_reset_busy));
  sw_irq_c:    cover property ($rose(s_q.stat[8]) ##[1:20] $fell(s_q.fsw));
  irq_c:       cover property ($rose(irq));

endmodule
